//--- shared/csq_defines.vh
// constants for the cleaning step sequencer
`ifndef CSQ_DEFINES_VH
`define CSQ_DEFINES_VH
`define CSQ_CLK_HZ        100000000
`define CSQ_TICK_DIV      (`CSQ_CLK_HZ / 1)
`define CSQ_NPROG         4
`define CSQ_NSTEP         30
`define CSQ_NOUT          4
`define CSQ_TYPE_SIMPLE   2'h0
`define CSQ_TYPE_CHEM     2'h1
`define CSQ_TYPE_TABLE    2'h2
`define CSQ_SIMPLE_MIN_S  10'h005
`define CSQ_SIMPLE_MAX_S  10'h258
`define CSQ_SIMPLE_RST_S  10'h00A
`define CSQ_CHEM_MAX_S    10'h384
`define CSQ_CHEM_CLN_RST  10'h005
`define CSQ_CHEM_RNS_RST  10'h000
`define CSQ_LIM_NONE      2'h0
`define CSQ_LIM_FIRST     2'h1
`define CSQ_LIM_SECOND    2'h2
`endif

//--- src/csq_sequencer.v
// cleaning step sequencer: four programs, one runs at a time
`timescale 1ns/1ns
`include "csq_defines.vh"
module csq_sequencer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // program configuration, 4 programs packed, then time settings shared by all programs
  input  wire [7:0]  prog_type,
  input  wire [3:0]  prog_hold_en,
  input  wire [15:0] prog_input_mask,
  input  wire [9:0]  simple_time,
  input  wire        simple_time_wr,
  input  wire [9:0]  chem_time,
  input  wire [1:0]  chem_time_sel,
  input  wire        chem_time_wr,
  // step table write port, step count, failsafe pattern and output count
  input  wire [4:0]  step_addr,
  input  wire [9:0]  step_dur,
  input  wire [3:0]  step_outs,
  input  wire [1:0]  step_lim_sel,
  input  wire        step_lim_level,
  input  wire        step_wr,
  input  wire [4:0]  step_count,
  input  wire [3:0]  failsafe_outs,
  input  wire [2:0]  out_count,
  // limit contacts
  input  wire [1:0]  lim_count,
  input  wire [1:0]  lim_src_fieldbus,
  input  wire        limit_contact_first,
  input  wire        limit_contact_second,
  input  wire [1:0]  lim_fieldbus,
  // commands
  input  wire [3:0]  start_req,
  input  wire        stop_req,
  input  wire        error_in,
  // outputs
  output reg  [3:0]  prog_active,
  output reg  [3:0]  act_out,
  output reg  [3:0]  input_hold,
  output reg         failsafe_on
);

  localparam ST_IDLE = 5'b00001;
  localparam ST_PRE  = 5'b00010;
  localparam ST_CLN  = 5'b00100;
  localparam ST_POST = 5'b01000;
  localparam ST_STEP = 5'b10000;

  reg [9:0]  step_dur_mem [0:`CSQ_NSTEP-1];
  reg [3:0]  step_out_mem [0:`CSQ_NSTEP-1];
  reg [1:0]  step_lsel_mem [0:`CSQ_NSTEP-1];
  reg        step_llev_mem [0:`CSQ_NSTEP-1];
  reg [9:0]  simple_s, pre_s, cln_s, post_s;
  reg [4:0]  state, step_idx;
  reg [1:0]  cur;
  reg [9:0]  remain;
  reg        timing;
  reg [26:0] div;
  reg        tick;
  reg [1:0]  lim_s1, lim_s2;
  reg [1:0]  fb_s1, fb_s2;
  reg        err_s1, err_s2;

  // unused table outputs forced off
  function [3:0] out_mask;
    input [2:0] n;
    begin
      out_mask = (n >= 3'h4) ? 4'hF : ((4'h1 << n) - 4'h1);
    end
  endfunction

  function [1:0] type_of;
    input [7:0] t;
    input [1:0] p;
    begin
      type_of = t[2*p +: 2];
    end
  endfunction

  wire [1:0] lim_src = {lim_src_fieldbus[1] ? fb_s2[1] : lim_s2[1],
                        lim_src_fieldbus[0] ? fb_s2[0] : lim_s2[0]};
  wire [1:0] lim_ok = {lim_count >= 2'h2, lim_count >= 2'h1};

  wire [1:0] cur_lsel = step_lsel_mem[step_idx];
  wire       cur_llev = step_llev_mem[step_idx];
  // contact beyond the configured count is treated as satisfied
  wire lim_met =
    (cur_lsel == `CSQ_LIM_FIRST)  ? (!lim_ok[0] ||
                                     lim_src[0] == cur_llev) :
    (cur_lsel == `CSQ_LIM_SECOND) ? (!lim_ok[1] ||
                                     lim_src[1] == cur_llev) : 1'b1;

  // first requesting program by lowest index
  reg [1:0] pick;
  reg       any_start;
  integer   i;
  always @* begin
    pick = 2'h0;
    any_start = 1'b0;
    for (i = `CSQ_NPROG - 1; i >= 0; i = i - 1) begin
      if (start_req[i]) begin
        pick = i[1:0];
        any_start = 1'b1;
      end
    end
  end

  // synchronisers for pins and fieldbus bits
  always @(posedge clk_sys) begin
    lim_s1 <= {limit_contact_second, limit_contact_first};
    lim_s2 <= lim_s1;
    fb_s1  <= lim_fieldbus;
    fb_s2  <= fb_s1;
    err_s1 <= error_in;
    err_s2 <= err_s1;
  end

  // one-second tick, held in reset while the sequencer is idle
  always @(posedge clk_sys) begin
    if (rst || (state == ST_IDLE)) begin
      div  <= 27'h0;
      tick <= 1'b0;
    end else if (div == `CSQ_TICK_DIV - 1) begin
      div  <= 27'h0;
      tick <= 1'b1;
    end else begin
      div  <= div + 27'h1;
      tick <= 1'b0;
    end
  end

  // timing parameters and table
  always @(posedge clk_sys) begin
    if (rst) begin
      simple_s <= `CSQ_SIMPLE_RST_S;
      pre_s    <= `CSQ_CHEM_RNS_RST;
      cln_s    <= `CSQ_CHEM_CLN_RST;
      post_s   <= `CSQ_CHEM_RNS_RST;
    end else begin
      // out of range writes are clamped
      if (simple_time_wr) begin
        if (simple_time < `CSQ_SIMPLE_MIN_S)
          simple_s <= `CSQ_SIMPLE_MIN_S;
        else if (simple_time > `CSQ_SIMPLE_MAX_S)
          simple_s <= `CSQ_SIMPLE_MAX_S;
        else
          simple_s <= simple_time;
      end
      if (chem_time_wr) begin
        case (chem_time_sel)
          2'h0: pre_s <= (chem_time > `CSQ_CHEM_MAX_S) ?
                         `CSQ_CHEM_MAX_S : chem_time;
          2'h1: cln_s <= (chem_time > `CSQ_CHEM_MAX_S) ?
                         `CSQ_CHEM_MAX_S : chem_time;
          2'h2: post_s <= (chem_time > `CSQ_CHEM_MAX_S) ?
                          `CSQ_CHEM_MAX_S : chem_time;
          default: ;
        endcase
      end
    end
  end

  always @(posedge clk_sys) begin
    if (step_wr && step_addr < `CSQ_NSTEP) begin
      step_dur_mem[step_addr]  <= step_dur;
      step_out_mem[step_addr]  <= step_outs;
      step_lsel_mem[step_addr] <= step_lim_sel;
      step_llev_mem[step_addr] <= step_lim_level;
    end
  end

  // main sequencer
  always @(posedge clk_sys) begin
    if (rst) begin
      state       <= ST_IDLE;
      cur         <= 2'h0;
      step_idx    <= 5'h0;
      remain      <= 10'h0;
      timing      <= 1'b0;
      prog_active <= 4'h0;
      act_out     <= 4'h0;
      input_hold  <= 4'h0;
      failsafe_on <= 1'b0;
    end else if (err_s2) begin
      // error ends the run and latches the failsafe pattern
      state       <= ST_IDLE;
      prog_active <= 4'h0;
      input_hold  <= 4'h0;
      act_out     <= failsafe_outs & out_mask(out_count);
      failsafe_on <= 1'b1;
    end else if (stop_req && state != ST_IDLE) begin
      state       <= ST_IDLE;
      prog_active <= 4'h0;
      input_hold  <= 4'h0;
      act_out     <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          // a running program ignores new starts, so first one wins
          if (any_start && !stop_req) begin
            failsafe_on <= 1'b0;
            cur         <= pick;
            prog_active <= 4'h1 << pick;
            input_hold  <= prog_hold_en[pick] ?
                           prog_input_mask[4*pick +: 4] : 4'h0;
            timing      <= 1'b1;
            step_idx    <= 5'h0;
            case (type_of(prog_type, pick))
              `CSQ_TYPE_CHEM: begin
                state   <= ST_PRE;
                remain  <= pre_s;
                act_out <= 4'h0;
              end
              `CSQ_TYPE_TABLE: begin
                state   <= (step_count == 5'h0) ? ST_IDLE : ST_STEP;
                remain  <= step_dur_mem[0];
                timing  <= 1'b0;
                act_out <= step_out_mem[0] & out_mask(out_count);
                if (step_count == 5'h0) begin
                  prog_active <= 4'h0;
                  input_hold  <= 4'h0;
                end
              end
              default: begin
                state   <= ST_CLN;
                remain  <= simple_s;
                act_out <= 4'h1;
              end
            endcase
          end
        end
        ST_PRE, ST_CLN, ST_POST: begin
          // zero-length phases pass in one cycle
          if (remain == 10'h0) begin
            if (state == ST_PRE) begin
              state   <= ST_CLN;
              remain  <= cln_s;
              act_out <= 4'h1;
            end else if (state == ST_CLN &&
                         type_of(prog_type, cur) == `CSQ_TYPE_CHEM) begin
              state   <= ST_POST;
              remain  <= post_s;
              act_out <= 4'h0;
            end else begin
              state       <= ST_IDLE;
              act_out     <= 4'h0;
              prog_active <= 4'h0;
              input_hold  <= 4'h0;
            end
          end else if (tick) begin
            remain <= remain - 10'h1;
          end
        end
        ST_STEP: begin
          if (!timing) begin
            timing <= lim_met;
          end else if (remain == 10'h0) begin
            if (step_idx + 5'h1 >= step_count ||
                step_idx == `CSQ_NSTEP - 1) begin
              state       <= ST_IDLE;
              act_out     <= 4'h0;
              prog_active <= 4'h0;
              input_hold  <= 4'h0;
            end else begin
              step_idx <= step_idx + 5'h1;
              remain   <= step_dur_mem[step_idx + 5'h1];
              act_out  <= step_out_mem[step_idx + 5'h1] &
                          out_mask(out_count);
              timing   <= 1'b0;
            end
          end else if (tick) begin
            remain <= remain - 10'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

//--- test/csq_seq_chk.sv
// port checker for the cleaning step sequencer
`timescale 1ns/1ns
module csq_seq_chk (
  // clock and reset
  input wire        clk_sys,
  input wire        rst,
  // watched inputs
  input wire [7:0]  prog_type,
  input wire [3:0]  start_req,
  input wire        stop_req,
  input wire        error_in,
  input wire [3:0]  failsafe_outs,
  input wire [2:0]  out_count,
  // watched outputs
  input wire [3:0]  prog_active,
  input wire [3:0]  act_out,
  input wire [3:0]  input_hold,
  input wire        failsafe_on
);
  reg  [1:0] eh;
  wire       quiet = !error_in && eh == 2'h0;
  wire       run = |prog_active;
  wire       tbl = prog_active[0] && prog_type[1:0] == 2'h2;
  // the synchroniser lags two edges, so recent error history counts
  always @(posedge clk_sys)
    eh <= rst ? 2'h0 : {eh[0], error_in};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_one_running: assert property ($onehot0(prog_active))
    else $error("more than one program active");
  a_start_taken: assert property (!run && start_req == 4'h2 &&
    !stop_req && quiet && prog_type[3:2] == 2'h0
    |=> prog_active == 4'h2 && act_out[0]) else $error("start not taken");
  a_first_kept: assert property ($past(run) && run
    |-> prog_active == $past(prog_active)) else $error("program switched");
  a_stop_ends: assert property (run && stop_req |=> !run)
    else $error("stop ignored");
  a_simple_min: assert property (prog_active == 4'h2 && quiet &&
    prog_type[3:2] == 2'h0 && !stop_req |=> prog_active == 4'h2
    && act_out[0]) else $error("simple cleaning ended early");
  a_error_safe: assert property (error_in [*3]
    |=> failsafe_on && !run) else $error("error not handled");
  a_safe_pattern: assert property (failsafe_on && $past(failsafe_on)
    && $stable(failsafe_outs) && $stable(out_count) && out_count <= 3'h4
    |-> act_out == (failsafe_outs & ~(4'hF << out_count)))
    else $error("wrong failsafe pattern");
  a_hold_idle: assert property (!run && !$past(run)
    |-> input_hold == 4'h0) else $error("hold while idle");
  a_unused_out: assert property (tbl && $past(tbl) && out_count == 3'h3
    && $stable(out_count) && !failsafe_on |-> !act_out[3])
    else $error("unused output driven");
endmodule
bind csq_sequencer csq_seq_chk u_chk (
  .clk_sys(clk_sys), .rst(rst), .prog_type(prog_type),
  .start_req(start_req), .stop_req(stop_req), .error_in(error_in),
  .failsafe_outs(failsafe_outs), .out_count(out_count),
  .prog_active(prog_active), .act_out(act_out),
  .input_hold(input_hold), .failsafe_on(failsafe_on)
);

//--- test/csq_far_side.sv
// far-side model: assembly valve and its limit switches
`timescale 1ns/1ns
module csq_far_side #(
  parameter TRAVEL = 40
) (
  // clock
  input  wire       clk_sys,
  // valve drive in, position out
  input  wire [3:0] act_out,
  output reg        at_service
);
  integer cnt = 0;
  initial at_service = 1'b0;
  // level 1 opens the valve, moving the sensor into the rinse chamber
  always @(posedge clk_sys) begin
    cnt <= (act_out[0] != at_service) ? cnt + 1 : 0;
    if (act_out[0] != at_service && cnt == TRAVEL - 1)
      at_service <= act_out[0];
  end
endmodule

//--- test/test_cleaning_step_sequencer.sv
// self-checking bench for the cleaning step sequencer
`timescale 1ns/1ns
module test_cleaning_step_sequencer;
  reg         clk_sys = 0, rst = 1, stop_req = 0, error_in = 0, rec = 0;
  reg         simple_time_wr = 0, chem_time_wr = 0, step_wr = 0, lim_lv = 0;
  reg  [7:0]  prog_type = 8'h42;
  reg  [15:0] prog_input_mask = 16'h0000;
  reg  [9:0]  simple_time = 0, chem_time = 0, step_dur = 0;
  reg  [4:0]  step_addr = 0, step_count = 5'h04;
  reg  [3:0]  start_req = 0, step_outs = 0, fs = 0, prog_hold_en = 0, last;
  reg  [3:0]  seen [0:7];
  reg  [2:0]  out_count = 3'h3;
  reg  [1:0]  chem_sel = 0, lim_sel = 0, lim_src = 0, lim_fb = 0;
  reg  [31:0] rs = 32'hF892B7C2;
  reg  [3:0]  o1, o2;
  wire [3:0]  prog_active, act_out, input_hold;
  wire        failsafe_on, pos;
  integer     miscompares = 0, n_checks = 0, ns = 0, n;
  always #5 clk_sys = ~clk_sys;
  csq_sequencer DUT (.clk_sys(clk_sys), .rst(rst), .prog_type(prog_type),
    .prog_hold_en(prog_hold_en), .prog_input_mask(prog_input_mask),
    .simple_time(simple_time), .simple_time_wr(simple_time_wr),
    .chem_time(chem_time), .chem_time_sel(chem_sel),
    .chem_time_wr(chem_time_wr), .step_addr(step_addr), .step_dur(step_dur),
    .step_outs(step_outs), .step_lim_sel(lim_sel), .step_lim_level(lim_lv),
    .step_wr(step_wr), .step_count(step_count), .failsafe_outs(fs),
    .out_count(out_count), .lim_count(2'h2), .lim_src_fieldbus(lim_src),
    .limit_contact_first(pos), .limit_contact_second(pos),
    .lim_fieldbus(lim_fb), .start_req(start_req), .stop_req(stop_req),
    .error_in(error_in), .prog_active(prog_active), .act_out(act_out),
    .input_hold(input_hold), .failsafe_on(failsafe_on));
  csq_far_side #(.TRAVEL(40)) u_far (.clk_sys(clk_sys), .act_out(act_out),
    .at_service(pos));
  function [31:0] xs(input [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  function [3:0] mo(input [3:0] o);
    mo = o & ~(4'hF << out_count);
  endfunction
  task tick(input integer k);
    repeat (k) @(negedge clk_sys);
  endtask
  task chk(input bit ok, input [8*20-1:0] msg);
    n_checks = n_checks + 1;
    if (!ok) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0t %0s", $time, msg);
    end
  endtask
  task wstep(input [4:0] a, input [3:0] o, input [1:0] ls, input lv);
    step_addr = a; step_outs = o; lim_sel = ls; lim_lv = lv; step_wr = 1;
    tick(1);
    step_wr = 0;
  endtask
  task wchem(input [1:0] s, input [9:0] t);
    chem_sel = s; chem_time = t; chem_time_wr = 1;
    tick(1);
    chem_time_wr = 0;
  endtask
  task go(input [3:0] m);
    start_req = m;
    tick(1);
    start_req = 0;
  endtask
  task halt;
    stop_req = 1;
    tick(1);
    stop_req = 0;
  endtask
  task idle_wait;
    n = 0;
    while (prog_active !== 4'h0 && n < 500) begin
      tick(1);
      n = n + 1;
    end
  endtask
  task give_verdict;
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(negedge clk_sys)
    if (rec && act_out !== last) begin
      if (ns < 8) seen[ns] = act_out;
      ns = ns + 1;
      last = act_out;
    end
  initial begin
    #200000;
    miscompares = miscompares + 1;
    give_verdict;
  end
  initial begin
    tick(20);
    rst = 0;
    chk({prog_active, act_out, input_hold, failsafe_on} === 13'h0, "reset");
    rs = xs(rs); o1 = rs[3:0] | 4'h3; o2 = o1 ^ 4'h6; fs = rs[7:4];
    prog_input_mask = rs[23:8];
    wstep(0, 4'h1, 2'h1, 1); wstep(1, o1, 0, 0);
    wstep(2, o2, 0, 0); wstep(3, 4'h0, 2'h2, 0);
    last = 0; rec = 1;
    go(4'h1);
    chk(prog_active === 4'h1, "table start");
    idle_wait;
    rec = 0;
    chk(n >= 80 && n < 110, "limit wait time");
    chk(ns == 4 && seen[1] === mo(o1) && seen[2] === mo(o2), "steps");
    chk(seen[0] === 4'h1 && seen[3] === 4'h0, "step ends");
    lim_src = 2'h1;
    go(4'h1);
    tick(200);
    chk(prog_active === 4'h1 && act_out === 4'h1, "fieldbus wait");
    lim_fb = 2'h1;
    idle_wait;
    chk(n < 80, "fieldbus release");
    lim_src = 0;
    simple_time = rs[31:22]; simple_time_wr = 1;
    tick(1);
    simple_time_wr = 0; prog_hold_en = 4'h2;
    go(4'h2);
    tick(1);
    chk(act_out[0] === 1'b1 && input_hold === prog_input_mask[7:4], "hold");
    go(4'h1);
    chk(prog_active === 4'h2, "first kept");
    halt;
    chk(prog_active === 4'h0 && act_out === 4'h0, "stop");
    go(4'hC);
    chk(prog_active === 4'h4, "lowest wins");
    halt;
    go(4'h8);
    tick(300);
    chk(prog_active === 4'h8, "clean default");
    halt;
    wchem(0, 0); wchem(1, 0); wchem(2, 0);
    go(4'h8);
    idle_wait;
    chk(n < 10, "zero phases");
    go(4'h2);
    error_in = 1;
    tick(3);
    error_in = 0;
    tick(2);
    chk(failsafe_on === 1'b1 && act_out === mo(fs), "failsafe");
    go(4'h2);
    chk(failsafe_on === 1'b0 && prog_active === 4'h2, "restart");
    halt;
    give_verdict;
  end
endmodule
